// file: pulse_width_counter.sv
/*
 Pulse width counter: noise filter, 8-bit width counter, six-entry
 queue with level bit, status flags and interrupt request.
 Assumes the core clock is the main oscillator, the slow crystal clock
 arrives as a pin level, and stop_mode_i comes from logic on core_clk_i.
*/
// The implementer's own choice: strobed register access.
`timescale 1ns/100ps
`include "pulse_width_defs.svh"
module pulse_width_counter (
  input  wire logic       core_clk_i,
  input  wire logic       rst_n_i,
  input  wire logic [7:0] addr_i,
  input  wire logic [7:0] wdata_i,
  input  wire logic       wr_i,
  input  wire logic       rd_i,
  output logic      [7:0] rdata_o,
  input  wire logic       pulse_input_i,
  input  wire logic       slow_crystal_clock_i,
  input  wire logic       stop_mode_i,
  output logic            irq_o,
  output logic            wake_o,
  output logic            pin_owned_o
);
  import pulse_width_pkg::*;

  // ==========================================================
  // Helpers
  // ==========================================================

  // Prescaler tick when the masked low bits are all ones
  function automatic logic tick_at(input logic [8:0] pre,
                                   input logic [8:0] mask);
    tick_at = ((pre & mask) == mask);
  endfunction : tick_at

  // Next queue pointer with wrap at the last entry
  function automatic logic [2:0] ptr_inc(input logic [2:0] p);
    ptr_inc = (p == `PTR_LAST) ? 3'h0 : p + 3'h1;
  endfunction : ptr_inc

  unit_state_t st;
  unit_state_t next_st;

  logic       on;
  logic       main_run;
  logic       x_tick;
  logic       nc_tick;
  logic       cnt_tick;
  logic       raw;
  logic       rise;
  logic       fall;
  logic       qual;
  logic       store;
  logic [8:0] nc_mask;
  logic [8:0] cc_mask;
  logic [2:0] last;
  logic [8:0] head;

  // ==========================================================
  // Clock selection and edge qualification
  // ==========================================================

  // Sample and count rates from prescaler or slow crystal
  always_comb begin
    on = st.ctl[`CTL_ON];
    main_run = on && !stop_mode_i; // R21
    x_tick = on && st.x2 && !st.x3;
    unique case (st.ctl[1:0])
      `NC_DIV32: nc_mask = `MASK32;
      `NC_DIV64: nc_mask = `MASK64;
      default:   nc_mask = `MASK16;
    endcase
    unique case (st.ctl[3:2])
      `CC_DIV64:  cc_mask = `MASK64;
      `CC_DIV128: cc_mask = `MASK128;
      `CC_DIV512: cc_mask = `MASK512;
      default:    cc_mask = `MASK32;
    endcase
    if (st.ctl[1:0] == `NC_SLOW_CRYSTAL_CLOCK) begin
      nc_tick  = x_tick; // R1
      cnt_tick = x_tick && st.xhalf; // R8
    end else begin
      nc_tick  = main_run && tick_at(st.pre, nc_mask); // R1
      cnt_tick = main_run && tick_at(st.pre, cc_mask); // R7
    end
    raw  = st.p2 ^ st.ctl[`CTL_INVERT]; // R18
    rise = st.sig && !st.sig_d; // R25
    fall = !st.sig && st.sig_d; // R25
    // Split mode counts both edges, period mode rising only
    qual = st.ctl[`CTL_SPLIT] ? (rise || fall) : rise; // R2 R16
    store = qual && (st.meas == MEAS_RUN) && !st.count_overflow_flag; // R3 R5
    last = (st.wptr == 3'h0) ? `PTR_LAST : st.wptr - 3'h1;
    head = st.mem[st.rptr];
  end

  // ==========================================================
  // Next state
  // ==========================================================

  always_comb begin
    next_st = st;
    // Synchronisers for the pins
    next_st.p1 = pulse_input_i;
    next_st.p2 = st.p1;
    next_st.x1 = slow_crystal_clock_i;
    next_st.x2 = st.x1;
    next_st.x3 = st.x2;
    next_st.rdata = 8'h00;

    // Divider of the main clock, counting while on and out of stop mode
    if (main_run) begin
      next_st.pre = st.pre + 9'h001;
    end
    if (x_tick) begin
      next_st.xhalf = !st.xhalf;
    end

    // Noise filter: level changes after three equal samples
    next_st.sig_d = st.sig;
    if (nc_tick) begin
      next_st.smp = {st.smp[1:0], raw};
      if (&{st.smp[1:0], raw}) begin
        next_st.sig = 1'b1;
      end else if (~|{st.smp[1:0], raw}) begin
        next_st.sig = 1'b0;
      end
    end

    // Width counter with saturation at all ones
    if (cnt_tick && st.meas == MEAS_RUN) begin
      if (st.cnt == `CNT_MAX) begin
        next_st.count_overflow_flag = 1'b1; // R4
        next_st.irqf = 1'b1; // R4
      end else begin
        next_st.cnt = st.cnt + 8'h01;
      end
    end

    // Edge handling: start, store and restart
    if (qual) begin
      next_st.meas = MEAS_RUN; // R25
      if (!st.count_overflow_flag || st.meas == MEAS_IDLE) begin
        next_st.cnt = 8'h00; // R3
      end else if (fall) begin
        next_st.cnt = 8'h00; // R6
      end
    end

    // Register reads
    if (rd_i) begin
      unique case (addr_i)
        `OFS_CONTROL: next_st.rdata = st.ctl;
        `OFS_STATUS: begin
          next_st.rdata = {st.pl, st.sig, st.ie, st.count_overflow_flag,
                           st.irqf, st.queue_overrun_flag, st.qcnt == `QUEUE_FULL,
                           st.qcnt == 3'h0}; // R19
          if (st.irqf) begin
            next_st.armed = 1'b1; // R20
          end
        end
        `OFS_QUEUE: begin
          next_st.rdata = head[7:0]; // R12
          if (st.qcnt != 3'h0) begin
            next_st.rptr = ptr_inc(st.rptr); // R12
            next_st.qcnt = st.qcnt - 3'h1; // R12
            next_st.pl = head[8]; // R13
          end
          if (st.armed) begin
            next_st.irqf = 1'b0; // R20
            next_st.armed = 1'b0;
          end
        end
        default: next_st.rdata = 8'h00;
      endcase
    end

    // Queue write; newest entry overwritten when full
    if (store) begin
      if (next_st.qcnt == `QUEUE_FULL) begin
        next_st.mem[last] = {st.sig_d, st.cnt}; // R11
        next_st.queue_overrun_flag = 1'b1; // R24
      end else begin
        next_st.mem[st.wptr] = {st.sig_d, st.cnt}; // R10
        next_st.wptr = ptr_inc(st.wptr); // R10
        next_st.qcnt = next_st.qcnt + 3'h1; // R10
        if (!st.ctl[`CTL_IRQ_SRC] &&
            next_st.qcnt == `QUEUE_IRQ) begin
          next_st.irqf = 1'b1; // R17
        end
      end
    end
    // Edge source sets pending; set beats any clear above
    if (st.ctl[`CTL_IRQ_SRC] && rise) begin
      next_st.irqf = 1'b1; // R17
    end
    if (cnt_tick && st.meas == MEAS_RUN && st.cnt == `CNT_MAX) begin
      next_st.irqf = 1'b1; // R4
    end

    // Register writes
    if (wr_i) begin
      if (addr_i == `OFS_CONTROL) begin
        next_st.ctl = wdata_i;
      end
      if (addr_i == `OFS_STATUS) begin
        next_st.ie = wdata_i[`STS_IE];
      end
    end

    // Unit off: queue, flags and measurement back to reset
    if (!on) begin
      next_st.count_overflow_flag  = 1'b0; // R14
      next_st.irqf  = 1'b0; // R14
      next_st.armed = 1'b0;
      next_st.queue_overrun_flag   = 1'b0; // R24
      next_st.pl    = 1'b0; // R14
      next_st.qcnt  = 3'h0; // R14
      next_st.rptr  = 3'h0;
      next_st.wptr  = 3'h0;
      next_st.pre   = 9'h000;
      next_st.xhalf = 1'b0;
      next_st.meas  = MEAS_IDLE; // R25
      next_st.cnt   = 8'h00;
      next_st.smp   = 3'h0;
      next_st.sig   = 1'b0;
      next_st.sig_d = 1'b0;
    end
  end

  // ==========================================================
  // State register
  // ==========================================================

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      st     <= '0;
      st.ctl <= `CTL_RESET;
      st.meas <= MEAS_IDLE;
    end else begin
      st <= next_st;
    end
  end

  // ==========================================================
  // Outputs
  // ==========================================================

  // Interrupt gated by enable; wake only when the unit can run
  always_comb begin
    rdata_o     = st.rdata;
    irq_o       = st.irqf && st.ie; // R23
    wake_o      = irq_o && (!stop_mode_i ||
                  st.ctl[1:0] == `NC_SLOW_CRYSTAL_CLOCK); // R21 R22
    pin_owned_o = on; // R14
  end
endmodule : pulse_width_counter

// file: pulse_width_defs.svh
/*
 Constants of the pulse width unit: offsets, fields, reset values, dividers.
 Assumes a byte-wide register port and a 100 MHz core clock.
*/
// Contract
// R1 - Noise sample rate: main clock /16, /32, /64, or slow crystal.
// R2 - Counter starts on a filtered edge; rising only or both edges.
// R3 - Next qualifying edge stores the count in the queue, clears counter.
// R4 - Overflow holds counter at all-ones, sets overflow flag, requests interrupt.
// R5 - Edge during overflow flag does not store the saturated count.
// R6 - Falling edge during overflow flag clears counter and resumes counting. Code: split mode only; in period mode the counter holds all-ones.
// R7 - Main-clock count rate: /32, /64, /128 or /512 by count select.
// R8 - Slow crystal noise source: counter runs at slow crystal /2.
// R9 - Software never picks a count rate faster than the sample rate.
// R10 - Six-entry queue fills from first entry onward in order.
// R11 - Full queue sets full flag; later results overwrite newest entry.
// R12 - Port read returns oldest entry and frees it; empty flag when drained.
// R13 - Stored level bit updates only after a port read.
// R14 - Unit off: clocks gated, queue and flags reset, pin released.
// R15 - Software keeps selects fixed while enabled; re-enable recovers overrun.
// R16 - Split select: high and low levels apart, else full periods.
// R17 - Pending flag on filtered rising edge, or after four queued results.
// R18 - Polarity bit inverts the input before filtering.
// R19 - Filtered level readable at any time in status.
// R20 - Pending flag clears on status read while set, then port access.
// R21 - Stop mode: runs and wakes only on slow crystal noise source.
// R22 - Wait mode: measuring continues, interrupt may end the wait.
// R23 - Interrupt request driven only when interrupt enable bit set.
// R24 - Write to full queue sets overrun flag; only disable clears it.
// R25 - Edge is a filtered change between samples; idle until first edge.
`ifndef PULSE_WIDTH_DEFS_SVH
`define PULSE_WIDTH_DEFS_SVH

// Register offsets
`define OFS_CONTROL   8'h0D
`define OFS_STATUS    8'h0E
`define OFS_QUEUE     8'h0F

// Control and status fields
`define CTL_RESET     8'h0F
`define CTL_ON        7
`define CTL_SPLIT     6
`define CTL_IRQ_SRC   5
`define CTL_INVERT    4
`define STS_IE        5

// Select codes and figures
`define NC_SLOW_CRYSTAL_CLOCK       2'h3
`define CC_DIV64      2'h1
`define CC_DIV128     2'h2
`define CC_DIV512     2'h3
`define NC_DIV32      2'h1
`define NC_DIV64      2'h2
`define QUEUE_DEPTH   6
`define QUEUE_FULL    3'h6
`define QUEUE_IRQ     3'h4
`define PTR_LAST      3'h5
`define CNT_MAX       8'hFF

// Prescaler masks: tick when low bits all ones
`define MASK16        9'h00F
`define MASK32        9'h01F
`define MASK64        9'h03F
`define MASK128       9'h07F
`define MASK512       9'h1FF

`endif

// file: pulse_width_pkg.sv
/*
 Types of the pulse width unit.
 Assumes the constants header is on the include path.
*/
package pulse_width_pkg;
  `include "pulse_width_defs.svh"

  typedef enum logic {MEAS_IDLE, MEAS_RUN} meas_t;

  // Whole state of the unit
  typedef struct packed {
    logic [7:0]      ctl;
    logic            ie;
    logic            count_overflow_flag;
    logic            irqf;
    logic            armed;
    logic            queue_overrun_flag;
    logic            pl;
    logic [2:0]      qcnt;
    logic [2:0]      rptr;
    logic [2:0]      wptr;
    logic [5:0][8:0] mem;
    logic [8:0]      pre;
    logic            p1;
    logic            p2;
    logic            x1;
    logic            x2;
    logic            x3;
    logic            xhalf;
    logic [2:0]      smp;
    logic            sig;
    logic            sig_d;
    meas_t           meas;
    logic [7:0]      cnt;
    logic [7:0]      rdata;
  } unit_state_t;
endpackage : pulse_width_pkg

// file: pulse_width_counter_monitor.sv
/* Port checker of the pulse width counter.
   Assumes one clock and a synchronous active-low reset. */
`timescale 1ns/100ps
module pulse_width_counter_monitor (
  input wire logic       core_clk_i,
  input wire logic       rst_n_i,
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic       wr_i,
  input wire logic       rd_i,
  input wire logic [7:0] rdata_o,
  input wire logic       pulse_input_i,
  input wire logic       slow_crystal_clock_i,
  input wire logic       stop_mode_i,
  input wire logic       irq_o,
  input wire logic       wake_o,
  input wire logic       pin_owned_o
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);
  // ==========================================
  // Register port and flags
  rd_idle_a: assert property (!$past(rd_i) |-> rdata_o == 8'h00)
    else $error("read data outside answer cycle");
  pin_own_a: assert property ($past(wr_i && addr_i == 8'h0D) |->
    pin_owned_o == $past(wdata_i[7])) else $error("pin owner wrong");
  ctl_read_a: assert property ($past(rd_i && addr_i == 8'h0D) |->
    rdata_o[7] == $past(pin_owned_o)) else $error("enable bit wrong");
  off_quiet_a: assert property (!pin_owned_o && $past(!pin_owned_o)
    |-> !irq_o) else $error("request while off");
  off_flags_a: assert property ($past(rd_i && addr_i == 8'h0E) &&
    $past(!pin_owned_o, 2) && $past(!pin_owned_o) |->
    rdata_o[4:0] == 5'h01) else $error("flags not cleared");
  full_excl_a: assert property ($past(rd_i && addr_i == 8'h0E) |->
    !(rdata_o[1] && rdata_o[0])) else $error("full and empty");
  irq_gate_a: assert property ($past(rd_i && addr_i == 8'h0E) &&
    !rdata_o[5] |-> !irq_o) else $error("request while masked");
  wake_gate_a: assert property (wake_o |-> irq_o)
    else $error("wake without request");
  wake_run_a: assert property (!stop_mode_i |-> wake_o == irq_o)
    else $error("wake lost while running");
endmodule : pulse_width_counter_monitor

bind pulse_width_counter pulse_width_counter_monitor u_mon (
  .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i),
  .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
  .pulse_input_i(pulse_input_i), .stop_mode_i(stop_mode_i),
  .slow_crystal_clock_i(slow_crystal_clock_i), .irq_o(irq_o),
  .wake_o(wake_o), .pin_owned_o(pin_owned_o));

// file: pulse_input_model.sv
/* Pulse source on the unit's input pin.
   Assumes the bench sets run, idle level and phase lengths. */
`timescale 1ns/100ps
module pulse_input_model (
  input  wire logic        core_clk_i,
  input  wire logic        run_i,
  input  wire logic        lvl_i,
  input  wire logic [15:0] hi_i,
  input  wire logic [15:0] lo_i,
  output logic             pulse_o
);
  logic [15:0] n;
  // Square wave while running, else held at the idle level
  always_ff @(posedge core_clk_i) begin
    if (!run_i) begin
      pulse_o <= lvl_i;
      n <= 16'h0000;
    end else if (n + 16'h0001 == (pulse_o ? hi_i : lo_i)) begin
      pulse_o <= !pulse_o;
      n <= 16'h0000;
    end else begin
      n <= n + 16'h0001;
    end
  end
endmodule : pulse_input_model

// file: pulse_width_counter_tb_top.sv
/* Bench of the pulse width counter.
   Assumes the pulse model and the bound checker. */
`timescale 1ns/100ps
module pulse_width_counter_tb_top;
  logic       core_clk_i = 1'b0;
  logic       rst_n_i = 1'b0;
  logic [7:0] addr_i = 8'h00;
  logic [7:0] wdata_i = 8'h00;
  logic       wr_i = 1'b0;
  logic       rd_i = 1'b0;
  logic       stop_mode_i = 1'b0;
  logic       run = 1'b0;
  logic       lvl = 1'b0;
  logic [2:0] xdiv = 3'h0;
  logic [7:0] rdata_o, s, v;
  logic       pulse, irq_o, wake_o, pin_owned_o;
  int         fails = 0, checks = 0, cyc = 0, i;
  logic [7:0] rows [3][3] = '{'{8'h0E, 8'h20, 8'h21},
    '{8'h30, 8'hFF, 8'h00}, '{8'h0D, 8'h0F, 8'h0F}};
  // ==========================================
  // Clock, timeout, instances
  always #5 core_clk_i = ~core_clk_i;
  // Slow crystal stand-in: rising edge every eighth cycle
  always @(posedge core_clk_i) xdiv <= xdiv + 3'h1;
  always @(posedge core_clk_i) begin
    cyc++;
    if (cyc == 60000) begin
      fails++;
      print_verdict();
    end
  end
  pulse_width_counter DUT (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
    .rdata_o(rdata_o), .pulse_input_i(pulse), .slow_crystal_clock_i(xdiv[2]),
    .stop_mode_i(stop_mode_i), .irq_o(irq_o), .wake_o(wake_o),
    .pin_owned_o(pin_owned_o));
  pulse_input_model u_src (.core_clk_i(core_clk_i), .run_i(run),
    .lvl_i(lvl), .hi_i(16'd320), .lo_i(16'd640), .pulse_o(pulse));
  // ==========================================
  // Tasks
  task chk(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      fails++;
      $display("Error %0t: got %h want %h", $time, seen, exp);
    end
  endtask : chk
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge core_clk_i);
    wr_i <= 1'b0;
  endtask : wr
  task rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge core_clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge core_clk_i);
    rd_i <= 1'b0;
    #1 d = rdata_o;
  endtask : rd
  task print_verdict();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : print_verdict
  // ==========================================
  // Main sequence
  initial begin
    repeat (2) @(posedge core_clk_i);
    rst_n_i <= 1'b1;
    rd(8'h0D, s);
    chk(s, 8'h0F);
    rd(8'h0E, s);
    chk(s, 8'h01);
    for (i = 0; i < 3; i++) begin
      wr(rows[i][0], rows[i][1]);
      rd(rows[i][0], s);
      chk(s, rows[i][2]);
    end
    $display("registers done");
    wr(8'h0D, 8'hC0);
    run <= 1'b1;
    for (i = 0; i < 6000 && irq_o !== 1'b1; i++) @(posedge core_clk_i);
    chk(irq_o, 1'b1);
    rd(8'h0E, s);
    chk(s[0], 1'b0);
    rd(8'h0F, v);
    chk(v >= 8'd9 && v <= 8'd11, 1'b1);
    chk(irq_o, 1'b0);
    rd(8'h0E, s);
    chk(s[7], 1'b1);
    rd(8'h0F, v);
    chk(v >= 8'd19 && v <= 8'd21, 1'b1);
    rd(8'h0E, s);
    chk(s[7], 1'b0);
    rd(8'h0F, v);
    chk(v >= 8'd9 && v <= 8'd11, 1'b1);
    rd(8'h0F, v);
    chk(v >= 8'd19 && v <= 8'd21, 1'b1);
    rd(8'h0E, s);
    chk(s[0], 1'b1);
    $display("measure done");
    repeat (5000) @(posedge core_clk_i);
    run <= 1'b0;
    lvl <= 1'b1;
    repeat (200) @(posedge core_clk_i);
    rd(8'h0E, s);
    chk(s[2:0], 3'b110);
    chk(s[6], 1'b1);
    for (i = 0; i < 6; i++) rd(8'h0F, v);
    rd(8'h0E, s);
    chk(s[1:0], 2'b01);
    $display("queue done");
    repeat (9000) @(posedge core_clk_i);
    rd(8'h0E, s);
    chk(s[4], 1'b1);
    chk(irq_o, 1'b1);
    lvl <= 1'b0;
    repeat (200) @(posedge core_clk_i);
    rd(8'h0E, s);
    chk(s[0], 1'b1);
    stop_mode_i <= 1'b1;
    @(posedge core_clk_i);
    #1 chk(wake_o, 1'b0);
    stop_mode_i <= 1'b0;
    @(posedge core_clk_i);
    #1 chk(wake_o, 1'b1);
    $display("overflow done");
    wr(8'h0D, 8'h00);
    repeat (3) @(posedge core_clk_i);
    rd(8'h0E, s);
    chk(s[5:0], 6'h21);
    chk(pin_owned_o, 1'b0);
    wr(8'h0D, 8'h90);
    repeat (200) @(posedge core_clk_i);
    rd(8'h0E, s);
    chk(s[6], 1'b1);
    chk(pin_owned_o, 1'b1);
    $display("invert done");
    // Slow crystal source, edge interrupt, full periods
    wr(8'h0D, 8'h00);
    wr(8'h0D, 8'hA3);
    run <= 1'b1;
    for (i = 0; i < 3000 && irq_o !== 1'b1; i++) @(posedge core_clk_i);
    chk(irq_o, 1'b1);
    rd(8'h0E, s);
    chk(s[0], 1'b1);
    stop_mode_i <= 1'b1;
    @(posedge core_clk_i);
    #1 chk(wake_o, 1'b1);
    stop_mode_i <= 1'b0;
    repeat (1000) @(posedge core_clk_i);
    rd(8'h0F, v);
    chk(v >= 8'd59 && v <= 8'd61, 1'b1);
    chk(irq_o, 1'b0);
    $display("slow crystal done");
    // Other noise and count dividers on a 960-cycle period
    for (i = 0; i < 2; i++) begin
      run <= 1'b0;
      wr(8'h0D, 8'h00);
      wr(8'h0D, (i != 0) ? 8'h8E : 8'h89);
      run <= 1'b1;
      repeat (2300) @(posedge core_clk_i);
      rd(8'h0F, v);
      chk(v >= ((i != 0) ? 8'd1 : 8'd7) &&
          v <= ((i != 0) ? 8'd2 : 8'd8), 1'b1);
    end
    $display("divider modes done");
    // Reset in mid-run also clears the interrupt enable
    @(posedge core_clk_i);
    rst_n_i <= 1'b0;
    repeat (2) @(posedge core_clk_i);
    rst_n_i <= 1'b1;
    rd(8'h0D, s);
    chk(s, 8'h0F);
    rd(8'h0E, s);
    chk(s, 8'h01);
    $display("reset done");
    print_verdict();
  end
endmodule : pulse_width_counter_tb_top
